// ==== hdl/rpmc_defines.svh ====
/*
  Offsets, field positions, reset values and timing counts of the reset and
  power mode controller. Assumes inclusion by bare name from hdl/.
*/
`ifndef RPMC_DEFINES_SVH
`define RPMC_DEFINES_SVH

// ==========================================
// Register byte offsets
`define RPMC_OFF_SRC      12'h000
`define RPMC_OFF_CFG      12'h004
`define RPMC_OFF_MODE     12'h008
`define RPMC_OFF_STAT     12'h00C
`define RPMC_OFF_BOOT     12'h010

// ==========================================
// Reset source flag positions
`define RPMC_SRC_PIN      0
`define RPMC_SRC_POF      1
`define RPMC_SRC_BOF      2
`define RPMC_SRC_WDT      3
`define RPMC_SRC_SWR      4
`define RPMC_SRC_BRK      5
`define RPMC_SRC_W        6

// ==========================================
// Config fields
`define RPMC_CFG_RPE      0
`define RPMC_CFG_BOD_EN   1
`define RPMC_CFG_BOD_IRQ  2
`define RPMC_CFG_RC_SYS   3
`define RPMC_CFG_RTC_EN   4
`define RPMC_CFG_CMP_PD   5
`define RPMC_CFG_SWRST    6
`define RPMC_CFG_RESET    8'h02

// ==========================================
// Mode field encodings
`define RPMC_MODE_RUN     2'h0
`define RPMC_MODE_IDLE    2'h1
`define RPMC_MODE_PD      2'h2
`define RPMC_MODE_TPD     2'h3

// ==========================================
// Timing
`define RPMC_CLK_MHZ      100
`define RPMC_HOLD_NS      200
`define RPMC_HOLD_CYC     ((`RPMC_HOLD_NS * `RPMC_CLK_MHZ + 999) / 1000)

`endif

// ==== hdl/rpmc_hold.sv ====
/*
  Reset hold counter: keeps the core in reset while any request stands and
  for a short hold after. Assumes requests are synchronous to mclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rpmc_defines.svh"
module rpmc_hold #(
  parameter int HOLD_CYC = `RPMC_HOLD_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  rpmc_if.hold      bus
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       rst_q;
  logic       rst_d;

  always_comb begin
    cnt_d = cnt_q;
    rst_d = rst_q;
    if (bus.any_req) begin
      cnt_d = 8'(HOLD_CYC);
      rst_d = 1'b1;
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end else begin
      rst_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      rst_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      rst_q <= rst_d;
    end
  end

  assign bus.core_rst = rst_q;

  AST_HOLD_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    bus.any_req |=> bus.core_rst [*2])
    else $error("core reset released too early");
endmodule
`default_nettype wire

// ==== hdl/rpmc_if.sv ====
/*
  Interface between the controller top and its reset hold counter.
  Assumes one clock and one synchronised reset from the top.
*/
`timescale 1ns/10ps
`default_nettype none
interface rpmc_if;
  logic any_req;
  logic core_rst;
  modport ctl (output any_req, input core_rst);
  modport hold (input any_req, output core_rst);
endinterface
`default_nettype wire

// ==== hdl/rpmc_pkg.sv ====
/*
  Types shared by the reset and power mode controller files.
  Assumes rpmc_defines.svh sits in the same folder.
*/
package rpmc_pkg;
  typedef enum logic [1:0] {
    RPMC_RUN,
    RPMC_IDLE,
    RPMC_PD,
    RPMC_TPD
  } rpmc_mode_t;
  typedef logic [5:0] rpmc_src_t;
endpackage

// ==== hdl/rpmc_top.sv ====
/*
  Reset and power mode controller: collects reset causes into sticky flags,
  chooses the fetch vector, sequences idle and power-down modes and gates
  the monitors and RC oscillator. Assumes AXI4-Lite master on mclk, reset
  pin and monitor inputs asynchronous, power-on detect as a level.
*/
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rpmc_defines.svh"
module rpmc_top
  import rpmc_pkg::*;
#(
  parameter int HOLD_CYC = `RPMC_HOLD_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        por_det,
  input  wire logic        shared_reset_input_pin,
  input  wire logic        bod_det,
  input  wire logic        brownout_enable_fuse,
  input  wire logic        wdt_rst_req,
  input  wire logic        brk_det,
  input  wire logic        boot_status_bit,
  input  wire logic        isp_force,
  input  wire logic [7:0]  boot_vector,
  input  wire logic        wake_irq,
  input  wire logic        pd_wake_irq,
  output logic             core_rst,
  output logic [15:0]      fetch_addr,
  output logic             pin_digital_in,
  output logic             bod_irq,
  output logic             cpu_halt,
  output logic             osc_run,
  output logic             rc_osc_run,
  output logic             bod_run,
  output logic             cmp_run,
  output logic             wdt_run,
  output logic             rtc_run,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================
  // Reset release and input synchronisers
  logic [1:0] rs_q;
  logic       rst_n;
  logic [1:0] pin_s_q;
  logic [1:0] por_s_q;
  logic [1:0] bod_s_q;
  logic [1:0] brk_s_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rs_q    <= 2'h0;
      pin_s_q <= 2'h3;
      por_s_q <= 2'h3;
      bod_s_q <= 2'h0;
      brk_s_q <= 2'h0;
    end else begin
      rs_q    <= {rs_q[0], 1'b1};
      pin_s_q <= {pin_s_q[0], shared_reset_input_pin};
      por_s_q <= {por_s_q[0], por_det};
      bod_s_q <= {bod_s_q[0], bod_det};
      brk_s_q <= {brk_s_q[0], brk_det};
    end
  end
  assign rst_n = rs_q[1];

  logic pin_lvl;
  logic por_lvl;
  logic bod_lvl;
  logic brk_lvl;
  assign pin_lvl = pin_s_q[1];
  assign por_lvl = por_s_q[1];
  assign bod_lvl = bod_s_q[1];
  assign brk_lvl = brk_s_q[1];

  // ==========================================
  // Registers
  logic [5:0]  src_q,  src_d;
  logic [7:0]  cfg_q,  cfg_d;
  rpmc_mode_t  mode_q, mode_d;
  logic        boot_q, boot_d;
  logic        pup_q,  pup_d;
  logic        rst_prev_q;
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;

  // ==========================================
  // Reset requests
  logic bod_on;
  logic bod_rst_req;
  logic pin_rst_req;
  logic sw_req;
  logic any_req;
  logic wr_fire;

  assign bod_on = cfg_q[`RPMC_CFG_BOD_EN] && (mode_q != RPMC_TPD);
  assign bod_rst_req = bod_on && bod_lvl && !cfg_q[`RPMC_CFG_BOD_IRQ];
  assign bod_irq     = bod_on && bod_lvl && cfg_q[`RPMC_CFG_BOD_IRQ];
  // pin as reset only when enabled or during power-up
  assign pin_rst_req = !pin_lvl && (cfg_q[`RPMC_CFG_RPE] || pup_q);
  assign pin_digital_in = pin_lvl;
  assign sw_req = cfg_q[`RPMC_CFG_SWRST];
  assign any_req = por_lvl || pin_rst_req || bod_rst_req || wdt_rst_req
                   || sw_req || brk_lvl;

  rpmc_if hif ();
  assign hif.any_req = any_req;
  assign core_rst    = hif.core_rst;

  rpmc_hold #(.HOLD_CYC(HOLD_CYC)) u_hold (
    .mclk  (mclk),
    .rst_n (rst_n),
    .bus   (hif)
  );

  // ==========================================
  // Source flags, config, mode, boot choice
  always_comb begin
    src_d  = src_q;
    cfg_d  = cfg_q;
    mode_d = mode_q;
    boot_d = boot_q;
    pup_d  = pup_q;
    if (wr_fire && s_axi_wstrb[0]) begin
      case (awa_q)
        `RPMC_OFF_SRC:  src_d = src_q & wd_q[5:0];
        `RPMC_OFF_CFG:  cfg_d = {1'b0, wd_q[6:0]};
        `RPMC_OFF_MODE: mode_d = rpmc_mode_t'(wd_q[1:0]);
        default:        ;
      endcase
    end
    if (pin_rst_req) src_d[`RPMC_SRC_PIN] = 1'b1;
    if (bod_rst_req) src_d[`RPMC_SRC_BOF] = 1'b1;
    if (wdt_rst_req) src_d[`RPMC_SRC_WDT] = 1'b1;
    if (sw_req)      src_d[`RPMC_SRC_SWR] = 1'b1;
    if (brk_lvl)     src_d[`RPMC_SRC_BRK] = 1'b1;
    if (any_req) begin
      cfg_d[`RPMC_CFG_SWRST] = 1'b0;
      mode_d = RPMC_RUN;
    end else if (wake_irq && mode_q == RPMC_IDLE) begin
      mode_d = RPMC_RUN;
    end else if (pd_wake_irq && (mode_q == RPMC_PD || mode_q == RPMC_TPD)) begin
      mode_d = RPMC_RUN;
    end
    if (por_lvl) begin
      src_d = 6'h00;
      src_d[`RPMC_SRC_POF] = 1'b1;
      src_d[`RPMC_SRC_BOF] = 1'b1;
      pup_d = 1'b1;
      cfg_d = `RPMC_CFG_RESET;
    end else if (!core_rst) begin
      pup_d = 1'b0;
    end
    if (core_rst && !rst_prev_q) boot_d = 1'b0;
    if (brk_lvl || (por_lvl && isp_force)) boot_d = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_q      <= 6'h06;
      cfg_q      <= `RPMC_CFG_RESET;
      mode_q     <= RPMC_RUN;
      boot_q     <= 1'b0;
      pup_q      <= 1'b1;
      rst_prev_q <= 1'b1;
    end else begin
      src_q      <= src_d;
      cfg_q      <= cfg_d;
      mode_q     <= mode_d;
      boot_q     <= boot_d;
      pup_q      <= pup_d;
      rst_prev_q <= core_rst;
    end
  end

  assign fetch_addr = (boot_q || boot_status_bit) ? {boot_vector, 8'h00} : 16'h0000;

  // ==========================================
  // Power gating
  logic lp;
  assign lp       = (mode_q == RPMC_PD) || (mode_q == RPMC_TPD);
  assign cpu_halt = (mode_q != RPMC_RUN);
  assign osc_run  = !lp;
  assign wdt_run  = 1'b1;
  assign rtc_run  = cfg_q[`RPMC_CFG_RTC_EN];
  assign bod_run  = bod_on;
  assign cmp_run  = !cfg_q[`RPMC_CFG_CMP_PD] && (mode_q != RPMC_TPD);
  assign rc_osc_run = !lp || (cfg_q[`RPMC_CFG_RC_SYS] && cfg_q[`RPMC_CFG_RTC_EN]);

  // ==========================================
  // AXI4-Lite slave, one access each way
  assign wr_fire = aw_q && w_q && !b_q;

  always_comb begin
    aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
    awa_d = awa_q; wd_d = wd_q; rd_d = rd_q; br_d = br_q; rr_d = rr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = (awa_q == `RPMC_OFF_SRC || awa_q == `RPMC_OFF_CFG
              || awa_q == `RPMC_OFF_MODE) ? 2'h0 : 2'h2;
    end
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_d  = 1'b1;
      rr_d = 2'h0;
      case (s_axi_araddr)
        `RPMC_OFF_SRC:  rd_d = {26'h0, src_q};
        `RPMC_OFF_CFG:  rd_d = {24'h0, cfg_q};
        `RPMC_OFF_MODE: rd_d = {30'h0, mode_q};
        `RPMC_OFF_STAT: rd_d = {26'h0, bod_irq, bod_lvl, pin_lvl, cpu_halt, lp, core_rst};
        `RPMC_OFF_BOOT: rd_d = {16'h0, fetch_addr};
        default: begin
          rd_d = 32'h0;
          rr_d = 2'h2;
        end
      endcase
    end
    if (r_q && s_axi_rready) r_d = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 12'h000; wd_q <= 32'h0; rd_q <= 32'h0;
      br_q <= 2'h0; rr_q <= 2'h0;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d;
      br_q <= br_d; rr_q <= rr_d;
    end
  end

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // ==========================================
  // Checks
  AST_POR_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n)
    por_lvl |=> (src_q == 6'h06))
    else $error("power-on flags wrong");
  AST_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
    (!por_lvl && !wr_fire) |=> ((src_q & $past(src_q)) == $past(src_q)))
    else $error("flag lost without clear");
  AST_PIN_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_q[`RPMC_CFG_RPE] && !pup_q) |-> !pin_rst_req)
    else $error("pin reset while disabled");
  AST_BOD_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_q[`RPMC_CFG_BOD_EN] |-> (!bod_irq && !bod_rst_req))
    else $error("brownout active while disabled");
  AST_TPD_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_q == RPMC_TPD) |-> (!bod_run && !cmp_run && !osc_run))
    else $error("monitors on in total power-down");
  AST_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
    any_req |=> (mode_q == RPMC_RUN))
    else $error("reset did not end low power");
  AST_BOOT: assert property (@(posedge mclk) disable iff (!rst_n)
    brk_lvl |=> (fetch_addr == {boot_vector, 8'h00}))
    else $error("break reset not at boot address");
  AST_RC: assert property (@(posedge mclk) disable iff (!rst_n)
    (lp && !cfg_q[`RPMC_CFG_RTC_EN]) |-> !rc_osc_run)
    else $error("RC oscillator left running");
  // Power-up forces the pin into its reset role
  AST_PUP_PIN: assert property (@(posedge mclk) disable iff (!rst_n)
    (pup_q && !pin_lvl) |-> pin_rst_req)
    else $error("pin ignored during power-up");
  AST_PD_OSC: assert property (@(posedge mclk) disable iff (!rst_n)
    lp |-> (!osc_run && wdt_run))
    else $error("oscillator running in power-down");
  AST_FETCH_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    (!boot_q && !boot_status_bit) |-> (fetch_addr == 16'h0000))
    else $error("fetch not from zero");
endmodule
`default_nettype wire

// ==== tb/rpmc_partner.sv ====
/*
  Model of the outside reset circuit and on-chip supply monitors.
  Assumes the bench pulses go for one mclk cycle with an event code:
  1 pin, 2 power-on, 3 brownout, 4 watchdog, 5 break.
*/
`timescale 1ns/10ps
`default_nettype none
module rpmc_partner (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [2:0] ev,
  output logic            por_det,
  output logic            pin,
  output logic            bod_det,
  output logic            wdt_req,
  output logic            brk_det
);
  logic [2:0] ev_q;
  logic [3:0] cnt_q;
  logic       on;
  initial begin
    ev_q  = 3'h0;
    cnt_q = 4'h0;
  end
  // ==========================================
  // Event pulse, six cycles long
  always @(posedge mclk) begin
    if (go) begin
      ev_q  <= ev;
      cnt_q <= 4'h6;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign on      = (cnt_q != 4'h0);
  assign pin     = !(on && ev_q == 3'h1);
  assign por_det = on && ev_q == 3'h2;
  assign bod_det = on && ev_q == 3'h3;
  assign wdt_req = on && ev_q == 3'h4;
  assign brk_det = on && ev_q == 3'h5;
endmodule
`default_nettype wire

// ==== tb/test_reset_and_power_mode_control.sv ====
/*
  Self-checking bench of the reset and power mode controller.
  Assumes rpmc_top with a short hold count and the partner model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rpmc_defines.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module test_reset_and_power_mode_control;
  logic        mclk, rstn, go, boot_status_bit, wake_irq, pd_wake_irq, isp_f;
  logic [2:0]  ev;
  logic        por_det, pin, bod_det, wdt_req, brk_det;
  logic        core_rst, pin_digital_in, bod_irq, cpu_halt, osc_run;
  logic        rc_osc_run, bod_run, cmp_run, wdt_run, rtc_run;
  logic [15:0] fetch_addr;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
  logic [7:0]  bv;
  logic [33:0] er;
  logic [33:0] qr[$];
  logic [1:0]  qb[$];
  int          error_cnt = 0;
  int          n_tests = 0;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  rpmc_partner PART (.mclk(mclk), .go(go), .ev(ev), .por_det(por_det), .pin(pin),
    .bod_det(bod_det), .wdt_req(wdt_req), .brk_det(brk_det));

  // Fuse tied high: unprogrammed, no supply below 2.7 V here
  rpmc_top #(.HOLD_CYC(2)) DUT (.mclk(mclk), .rstn(rstn), .por_det(por_det),
    .shared_reset_input_pin(pin), .bod_det(bod_det), .brownout_enable_fuse(1'b1),
    .wdt_rst_req(wdt_req), .brk_det(brk_det), .boot_status_bit(boot_status_bit),
    .isp_force(isp_f), .boot_vector(bv), .wake_irq(wake_irq), .pd_wake_irq(pd_wake_irq),
    .core_rst(core_rst), .fetch_addr(fetch_addr), .pin_digital_in(pin_digital_in),
    .bod_irq(bod_irq), .cpu_halt(cpu_halt), .osc_run(osc_run), .rc_osc_run(rc_osc_run),
    .bod_run(bod_run), .cmp_run(cmp_run), .wdt_run(wdt_run), .rtc_run(rtc_run),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 50) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // ==========================================
  // AXI4-Lite master
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int  n;
    logic ha, hw, hb;
    qb.push_back(r);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      hb = s_axi_bvalid;
      @(posedge mclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    int  n;
    logic ha, hr;
    qr.push_back({r, e});
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk);
      ha = s_axi_arready;
      hr = s_axi_rvalid;
      @(posedge mclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask

  // ==========================================
  // Response watcher
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      er = qr.size() ? qr.pop_front() : 34'h3FFFFFFFF;
      `CHK("rdata", er, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid && s_axi_bready) begin
      eb = qb.size() ? qb.pop_front() : 2'h3;
      `CHK("bresp", eb, s_axi_bresp)
    end
  end

  // ==========================================
  // Reset events and waits
  task automatic wrel();
    int n;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk);
      if (core_rst === 1'b0) break;
    end
    tmo(n);
  endtask

  task automatic evt(input logic [2:0] c, input logic r, input logic i);
    @(posedge mclk);
    go <= 1'b1;
    ev <= c;
    @(posedge mclk);
    go <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK("core_rst", r, core_rst)
    `CHK("bod_irq", i, bod_irq)
    `CHK("pin_in", c != 3'h1, pin_digital_in)
    wrel();
    repeat (4) @(posedge mclk);
  endtask

  task automatic pulse(input logic pd);
    @(posedge mclk);
    if (pd) pd_wake_irq <= 1'b1;
    else wake_irq <= 1'b1;
    repeat (2) @(posedge mclk);
    pd_wake_irq <= 1'b0;
    wake_irq    <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    go = 1'b0;
    ev = 3'h0;
    boot_status_bit = 1'b0;
    wake_irq = 1'b0;
    pd_wake_irq = 1'b0;
    isp_f = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    rs = xs(32'h0000A267);
    bv = rs[7:0] | 8'h01;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (5) @(posedge mclk);
    rd(`RPMC_OFF_SRC, 32'h06, 2'h0);
    rd(`RPMC_OFF_CFG, 32'h02, 2'h0);
    rs = xs(rs);
    wr(`RPMC_OFF_SRC, {rs[31:8], 8'h00}, 2'h0);
    rd(`RPMC_OFF_SRC, 32'h00, 2'h0);
    wr(`RPMC_OFF_CFG, 32'h03, 2'h0);
    evt(3'h4, 1'b1, 1'b0);
    rd(`RPMC_OFF_SRC, 32'h08, 2'h0);
    wr(`RPMC_OFF_CFG, 32'h43, 2'h0);
    wrel();
    rd(`RPMC_OFF_SRC, 32'h18, 2'h0);
    rd(`RPMC_OFF_CFG, 32'h03, 2'h0);
    evt(3'h1, 1'b1, 1'b0);
    rd(`RPMC_OFF_SRC, 32'h19, 2'h0);
    wr(`RPMC_OFF_SRC, 32'h1E, 2'h0);
    rd(`RPMC_OFF_SRC, 32'h18, 2'h0);
    evt(3'h5, 1'b1, 1'b0);
    rd(`RPMC_OFF_BOOT, {16'h0, bv, 8'h00}, 2'h0);
    `CHK("fetch", {bv, 8'h00}, fetch_addr)
    evt(3'h4, 1'b1, 1'b0);
    rd(`RPMC_OFF_BOOT, 32'h0, 2'h0);
    boot_status_bit <= 1'b1;
    @(negedge mclk);
    `CHK("fetch", {bv, 8'h00}, fetch_addr)
    boot_status_bit <= 1'b0;
    wr(`RPMC_OFF_CFG, 32'h02, 2'h0);
    evt(3'h1, 1'b0, 1'b0);
    rd(`RPMC_OFF_SRC, 32'h38, 2'h0);
    evt(3'h3, 1'b1, 1'b0);
    rd(`RPMC_OFF_SRC, 32'h3C, 2'h0);
    wr(`RPMC_OFF_CFG, 32'h06, 2'h0);
    evt(3'h3, 1'b0, 1'b1);
    wr(`RPMC_OFF_CFG, 32'h00, 2'h0);
    evt(3'h3, 1'b0, 1'b0);
    @(posedge mclk);
    isp_f <= 1'b1;
    evt(3'h2, 1'b1, 1'b0);
    isp_f <= 1'b0;
    rd(`RPMC_OFF_BOOT, {16'h0, bv, 8'h00}, 2'h0);
    rd(`RPMC_OFF_SRC, 32'h06, 2'h0);
    rd(`RPMC_OFF_CFG, 32'h02, 2'h0);
    wr(`RPMC_OFF_CFG, 32'h1A, 2'h0);
    wr(`RPMC_OFF_MODE, 32'h1, 2'h0);
    `CHK("halt", 1'b1, cpu_halt)
    pulse(1'b0);
    `CHK("halt", 1'b0, cpu_halt)
    rd(`RPMC_OFF_MODE, 32'h0, 2'h0);
    wr(`RPMC_OFF_MODE, 32'h2, 2'h0);
    `CHK("osc", 1'b0, osc_run)
    `CHK("run", 5'h1F, {bod_run, wdt_run, cmp_run, rtc_run, rc_osc_run})
    pulse(1'b1);
    `CHK("osc", 1'b1, osc_run)
    wr(`RPMC_OFF_CFG, 32'h0A, 2'h0);
    wr(`RPMC_OFF_MODE, 32'h3, 2'h0);
    `CHK("tpd", 4'h0, {osc_run, bod_run, cmp_run, rc_osc_run})
    evt(3'h4, 1'b1, 1'b0);
    `CHK("osc", 1'b1, osc_run)
    rd(`RPMC_OFF_MODE, 32'h0, 2'h0);
    rd(12'h020, 32'h0, 2'h2);
    wr(12'h024, 32'hFF, 2'h2);
    repeat (4) @(posedge mclk);
    `CHK("queue", 0, qr.size() + qb.size())
    print_verdict();
  end
endmodule
`default_nettype wire
